// *** rtl/cdr_pkg.sv ***
// Purpose: Constants for the counter diagnostic record
// Assumes: 100 MHz mclk
// Notes:   Record byte indices are the order of the record itself

// ****************************************
// Package
// ****************************************
package cdr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

    localparam logic [4:0] IDX_FAULT_SUM = 5'h00;
    localparam logic [4:0] IDX_CLASS_INFO = 5'h01;
    localparam logic [4:0] IDX_SPARE = 5'h02;
    localparam logic [4:0] IDX_INT_DETAIL = 5'h03;
    localparam logic [4:0] IDX_CH_KIND = 5'h04;
    localparam logic [4:0] IDX_BITS_PER_CH = 5'h05;
    localparam logic [4:0] IDX_CH_COUNT = 5'h06;
    localparam logic [4:0] IDX_GROUP_FAULTS = 5'h07;
    localparam logic [4:0] IDX_LOST_CAUSE = 5'h08;
    localparam logic [4:0] IDX_STAMP0 = 5'h10;
    localparam logic [4:0] IDX_STAMP3 = 5'h13;

    localparam int unsigned FS_MODULE = 0;
    localparam int unsigned FS_EXTERNAL = 2;
    localparam int unsigned FS_CHANNEL = 3;
    localparam int unsigned FS_OUT_OVL = 4;
    localparam int unsigned ID_BUF_OVF = 3;
    localparam int unsigned ID_LOST = 6;
    localparam int unsigned GF_GROUP0 = 0;
    localparam int unsigned CI_PRESENT = 4;

    localparam logic [3:0] CLASS_FUNCTION = 4'h8;
    // Channel type code: arbitrary neutral value
    localparam logic [6:0] CH_KIND_CODE = 7'h2A;
    localparam logic [7:0] BITS_PER_CH = 8'h08;
    localparam logic [7:0] CH_COUNT = 8'h01;
    localparam logic [4:0] PEND_LIMIT = 5'h10;
    localparam logic [4:0] PEND_MAX = 5'h1F;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] STAMP_RST = 32'h0000_0000;
endpackage : cdr_pkg

// *** rtl/cdr_record.sv ***
// Purpose: Diagnostic record of a single-channel counter module
// Assumes: Event inputs come from counter logic on mclk; overload pins are asynchronous
// Notes:   Record read by byte index, answer one cycle after rd_en

`timescale 1ns/10ps

module cdr_record
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [4:0] proc_event,
    input  wire logic       proc_ack,
    input  wire logic       enc_supply_ovl,
    input  wire logic       dout_ovl,
    input  wire logic       diag_ack,
    input  wire logic       rd_en,
    input  wire logic [4:0] rd_idx,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic            diag_incoming,
    output logic            diag_going,
    output logic            diag_active,
    output logic            proc_pending
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [1:0] {
        CDR_IDLE   = 2'b01,
        CDR_ACTIVE = 2'b10
    } cdr_state_e;

    cdr_state_e  state_reg;
    cdr_state_e  state_next;
    logic        enc_s1_reg;
    logic        enc_s2_reg;
    logic        dout_s1_reg;
    logic        dout_s2_reg;
    logic        lost_reg;
    logic [4:0]  cause_reg;
    logic [4:0]  pend_cnt_reg;
    logic [6:0]  presc_reg;
    logic [31:0] ticker_reg;
    logic [7:0]  snap_fault_reg;
    logic [7:0]  snap_detail_reg;
    logic [4:0]  snap_cause_reg;
    logic [31:0] snap_stamp_reg;
    logic        cause_present;
    logic        lost_now;
    logic        capture;
    logic        enter;
    logic        leave;

    // ****************************************
    // Record byte decode
    // ****************************************
    function automatic logic [7:0] cdr_byte(input logic [4:0] idx,
                                            input logic [7:0] fault,
                                            input logic [7:0] detail,
                                            input logic [4:0] cause,
                                            input logic [31:0] stamp);
        logic [7:0] b;
        b = cdr_pkg::BYTE_RST;
        unique case (idx)
            cdr_pkg::IDX_FAULT_SUM:    b = fault;
            cdr_pkg::IDX_CLASS_INFO:   b = {3'h0, 1'b1, cdr_pkg::CLASS_FUNCTION};
            cdr_pkg::IDX_INT_DETAIL:   b = detail;
            cdr_pkg::IDX_CH_KIND:      b = {1'b0, cdr_pkg::CH_KIND_CODE};
            cdr_pkg::IDX_BITS_PER_CH:  b = cdr_pkg::BITS_PER_CH;
            cdr_pkg::IDX_CH_COUNT:     b = cdr_pkg::CH_COUNT;
            cdr_pkg::IDX_GROUP_FAULTS: b = {7'h00, fault[cdr_pkg::FS_CHANNEL]};
            cdr_pkg::IDX_LOST_CAUSE:   b = {3'h0, cause};
            cdr_pkg::IDX_STAMP0:       b = stamp[7:0];
            5'h11:                     b = stamp[15:8];
            5'h12:                     b = stamp[23:16];
            cdr_pkg::IDX_STAMP3:       b = stamp[31:24];
            default:                   b = cdr_pkg::BYTE_RST;
        endcase
        return b;
    endfunction : cdr_byte

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            enc_s1_reg  <= 1'b0;
            enc_s2_reg  <= 1'b0;
            dout_s1_reg <= 1'b0;
            dout_s2_reg <= 1'b0;
        end
        else
        begin
            enc_s1_reg  <= enc_supply_ovl;
            enc_s2_reg  <= enc_s1_reg;
            dout_s1_reg <= dout_ovl;
            dout_s2_reg <= dout_s1_reg;
        end
    end

    // ****************************************
    // Microsecond ticker
    // ****************************************
    // step and wrap
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            presc_reg  <= 7'h00;
            ticker_reg <= cdr_pkg::STAMP_RST;
        end
        else if (presc_reg == cdr_pkg::TICK_LAST)
        begin
            presc_reg  <= 7'h00;
            ticker_reg <= ticker_reg + 32'h0000_0001;
        end
        else
        begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    // ****************************************
    // Process alarm slot
    // ****************************************
    // dropped while active
    assign lost_now = proc_pending && (|proc_event) && (state_reg == CDR_IDLE);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            proc_pending <= 1'b0;
        else if (|proc_event)
            proc_pending <= 1'b1;
        else if (proc_ack)
            proc_pending <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            lost_reg  <= 1'b0;
            cause_reg <= 5'h00;
        end
        else if (lost_now)
        begin
            lost_reg  <= 1'b1;
            cause_reg <= cause_reg | proc_event;
        end
        else if (diag_ack)
        begin
            lost_reg  <= 1'b0;
            cause_reg <= 5'h00;
        end
    end

    // ****************************************
    // Diagnostic alarm sequencing
    // ****************************************
    assign cause_present = lost_reg || enc_s2_reg || dout_s2_reg;
    assign enter         = (state_reg == CDR_IDLE) && cause_present;
    assign leave         = (state_reg == CDR_ACTIVE) && !cause_present;
    assign capture       = enter || leave;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            CDR_IDLE:   if (cause_present) state_next = CDR_ACTIVE;
            CDR_ACTIVE: if (!cause_present) state_next = CDR_IDLE;
            default:    state_next = CDR_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg     <= CDR_IDLE;
            diag_incoming <= 1'b0;
            diag_going    <= 1'b0;
            diag_active   <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            diag_incoming <= enter;
            diag_going    <= leave;
            diag_active   <= (state_next == CDR_ACTIVE);
        end
    end

    // Pending count saturates; acks beyond zero are ignored
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            pend_cnt_reg <= 5'h00;
        else if (capture && !diag_ack && pend_cnt_reg != cdr_pkg::PEND_MAX)
            pend_cnt_reg <= pend_cnt_reg + 5'h01;
        else if (diag_ack && !capture && pend_cnt_reg != 5'h00)
            pend_cnt_reg <= pend_cnt_reg - 5'h01;
    end

    // ****************************************
    // Snapshot
    // ****************************************
    // captured as one
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            snap_fault_reg  <= cdr_pkg::BYTE_RST;
            snap_detail_reg <= cdr_pkg::BYTE_RST;
            snap_cause_reg  <= 5'h00;
            snap_stamp_reg  <= cdr_pkg::STAMP_RST;
        end
        else if (capture)
        begin
            snap_fault_reg <= cdr_pkg::BYTE_RST;
            snap_fault_reg[cdr_pkg::FS_MODULE]   <= lost_reg || enc_s2_reg;
            snap_fault_reg[cdr_pkg::FS_EXTERNAL] <= enc_s2_reg;
            snap_fault_reg[cdr_pkg::FS_CHANNEL]  <= lost_reg;
            snap_fault_reg[cdr_pkg::FS_OUT_OVL]  <= enc_s2_reg || dout_s2_reg;
            snap_detail_reg <= cdr_pkg::BYTE_RST;
            snap_detail_reg[cdr_pkg::ID_BUF_OVF] <= pend_cnt_reg >= cdr_pkg::PEND_LIMIT;
            snap_detail_reg[cdr_pkg::ID_LOST]    <= lost_reg;
            snap_cause_reg  <= cause_reg;
            snap_stamp_reg  <= ticker_reg;
        end
    end

    // ****************************************
    // Record read port
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data  <= cdr_pkg::BYTE_RST;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
                rd_data <= cdr_byte(rd_idx, snap_fault_reg, snap_detail_reg,
                                    snap_cause_reg, snap_stamp_reg);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_cause_gone;
        (state_reg == CDR_ACTIVE) && !cause_present;
    endsequence

    sequence s_going_seen;
        diag_going && !diag_active;
    endsequence

    property p_mod_err;
        capture && lost_reg |=> snap_fault_reg[0];
    endproperty
    a_mod_err: assert property (p_mod_err) else $error("module error not set");

    property p_ext_err;
        capture |=> snap_fault_reg[2] == $past(enc_s2_reg);
    endproperty
    a_ext_err: assert property (p_ext_err) else $error("external error wrong");

    property p_ch_err;
        capture |=> snap_fault_reg[3] == $past(lost_reg) && snap_detail_reg[6] == $past(lost_reg);
    endproperty
    a_ch_err: assert property (p_ch_err) else $error("channel error mismatch");

    property p_out_ovl;
        capture && dout_s2_reg |=> snap_fault_reg[4];
    endproperty
    a_out_ovl: assert property (p_out_ovl) else $error("output overload not set");

    property p_class;
        rd_en && rd_idx == 5'h01 |=> rd_valid && rd_data == 8'h18;
    endproperty
    a_class: assert property (p_class) else $error("module class byte wrong");

    property p_ovf;
        capture && pend_cnt_reg > cdr_pkg::PEND_LIMIT |=> snap_detail_reg[3];
    endproperty
    a_ovf: assert property (p_ovf) else $error("buffer overflow not set");

    property p_lost;
        lost_now |=> lost_reg && (cause_reg & $past(proc_event)) == $past(proc_event);
    endproperty
    a_lost: assert property (p_lost) else $error("lost alarm not flagged");

    property p_consts;
        rd_en && rd_idx == 5'h06 |=> rd_data == 8'h01;
    endproperty
    a_consts: assert property (p_consts) else $error("channel count wrong");

    property p_stamp;
        capture |=> snap_stamp_reg == $past(ticker_reg);
    endproperty
    a_stamp: assert property (p_stamp) else $error("time stamp not captured");

    property p_tick;
        presc_reg == cdr_pkg::TICK_LAST |=> ticker_reg == $past(ticker_reg) + 32'h0000_0001;
    endproperty
    a_tick: assert property (p_tick) else $error("ticker did not step");

    property p_going;
        s_cause_gone |=> s_going_seen ##1 !diag_going;
    endproperty
    a_going: assert property (p_going) else $error("outgoing alarm missing");

    property p_drop;
        (state_reg == CDR_ACTIVE) && !diag_ack |=> $stable(cause_reg);
    endproperty
    a_drop: assert property (p_drop) else $error("event stored while active");

    property p_reserved;
        rd_en && (rd_idx == 5'h02 || rd_idx == 5'h0C) |=> rd_data == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved byte not zero");

endmodule : cdr_record

// *** verif/cdr_reader_model.sv ***
// Purpose: Backplane reader model for the counter diagnostic record
// Assumes: One read or acknowledge at a time, driven just after mclk rises
// Notes:   Index lines toggle when idle so a stale index is never trusted

`timescale 1ns/10ps

// ****************************************
// Reader model
// ****************************************
module cdr_reader_model
(
    input  wire logic       mclk,
    output logic            rd_en,
    output logic      [4:0] rd_idx,
    output logic            diag_ack
);
    initial
    begin
        rd_en    = 1'b0;
        rd_idx   = 5'h15;
        diag_ack = 1'b0;
    end

    task automatic read_req(input logic [4:0] idx);
        @(posedge mclk);
        #1;
        rd_en  = 1'b1;
        rd_idx = idx;
        @(posedge mclk);
        #1;
        rd_en  = 1'b0;
        rd_idx = ~idx;
    endtask : read_req

    task automatic ack_diag();
        @(posedge mclk);
        #1;
        diag_ack = 1'b1;
        @(posedge mclk);
        #1;
        diag_ack = 1'b0;
    endtask : ack_diag
endmodule : cdr_reader_model

// *** verif/counter_diagnostic_record_tb_top.sv ***
// Purpose: Self-checking bench for the counter diagnostic record
// Assumes: Reader model issues reads; bench drives alarms and overloads
// Notes:   Expected bytes are queued by the driver, checked by a monitor

`timescale 1ns/10ps

// ****************************************
// Bench
// ****************************************
module counter_diagnostic_record_tb_top;
    logic        mclk;
    logic        rstn;
    logic  [4:0] proc_event;
    logic        proc_ack;
    logic        enc_supply_ovl;
    logic        dout_ovl;
    logic        diag_ack;
    logic        rd_en;
    logic  [4:0] rd_idx;
    logic  [7:0] rd_data;
    logic        rd_valid;
    logic        diag_incoming;
    logic        diag_going;
    logic        diag_active;
    logic        proc_pending;
    logic  [7:0] exp_q[$];
    logic  [7:0] mask_q[$];
    logic  [7:0] last_rd;
    logic [31:0] stamp;
    int          failures;
    int          samples_checked;
    int          cyc;
    int          evt_cyc;

    localparam logic [4:0] C_IDX [0:8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06,
                                            5'h00, 5'h03, 5'h07, 5'h08};
    localparam logic [7:0] C_EXP [0:8] = '{8'h18, 8'h00, {1'b0, cdr_pkg::CH_KIND_CODE},
                                            8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

    cdr_record dut_u
    (
        .mclk           (mclk),
        .rstn           (rstn),
        .proc_event     (proc_event),
        .proc_ack       (proc_ack),
        .enc_supply_ovl (enc_supply_ovl),
        .dout_ovl       (dout_ovl),
        .diag_ack       (diag_ack),
        .rd_en          (rd_en),
        .rd_idx         (rd_idx),
        .rd_data        (rd_data),
        .rd_valid       (rd_valid),
        .diag_incoming  (diag_incoming),
        .diag_going     (diag_going),
        .diag_active    (diag_active),
        .proc_pending   (proc_pending)
    );

    cdr_reader_model rdr_u
    (
        .mclk     (mclk),
        .rd_en    (rd_en),
        .rd_idx   (rd_idx),
        .diag_ack (diag_ack)
    );

    initial
    begin
        mclk = 1'b0;
    end

    always #5 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (!rstn)
            cyc <= 0;
        else
            cyc <= cyc + 1;
    end

    task automatic fail(input string msg);
        failures++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask : fail

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              input logic [7:0] mask);
        samples_checked++;
        if (((got ^ exp) & mask) !== 8'h00)
            fail($sformatf("byte got %h exp %h", got, exp));
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
            fail($sformatf("level got %b exp %b", got, exp));
    endtask : check_bit

    task automatic check_stamp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if ((^got === 1'bx) || (got > exp + 1) || (got + 1 < exp))
            fail($sformatf("stamp got %0d exp %0d", got, exp));
    endtask : check_stamp

    // Read answers leave the queue oldest first
    always @(posedge mclk)
    begin
        if (rd_valid === 1'b1)
        begin
            last_rd = rd_data;
            if (exp_q.size() == 0)
                fail("read answer without request");
            else
                check_byte(rd_data, exp_q.pop_front(), mask_q.pop_front());
        end
    end

    task automatic rd(input logic [4:0] idx, input logic [7:0] exp, input logic [7:0] mask);
        exp_q.push_back(exp);
        mask_q.push_back(mask);
        rdr_u.read_req(idx);
        @(posedge mclk);
        #1;
    endtask : rd

    task automatic pulse(input logic [4:0] ev, input logic ack);
        @(posedge mclk);
        #1;
        proc_event = ev;
        proc_ack   = ack;
        @(posedge mclk);
        #1;
        proc_event = 5'h00;
        proc_ack   = 1'b0;
    endtask : pulse

    task automatic wait_evt(input logic going);
        int n;
        n = 0;
        while (((going ? diag_going : diag_incoming) !== 1'b1) && (n < 60))
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 60)
            fail("diagnostic alarm missing");
        evt_cyc = cyc;
        #1;
        check_bit(diag_active, ~going);
    endtask : wait_evt

    task automatic ovl(input logic enc, input logic [7:0] fault, input logic [7:0] det);
        enc_supply_ovl = enc;
        dout_ovl       = ~enc;
        wait_evt(1'b0);
        rd(cdr_pkg::IDX_FAULT_SUM, fault, 8'hFF);
        rd(cdr_pkg::IDX_INT_DETAIL, det, 8'hFF);
        rd(cdr_pkg::IDX_GROUP_FAULTS, 8'h00, 8'hFF);
        enc_supply_ovl = 1'b0;
        dout_ovl       = 1'b0;
        wait_evt(1'b1);
        rd(cdr_pkg::IDX_FAULT_SUM, 8'h00, 8'hFF);
    endtask : ovl

    task automatic tally_and_finish();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if ((failures == 0) && (samples_checked > 0))
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Span covers all scenarios more than forty times over
    initial
    begin
        #200000;
        fail("watchdog expired");
        tally_and_finish();
    end

    initial
    begin
        rstn           = 1'b0;
        proc_event     = 5'h00;
        proc_ack       = 1'b0;
        enc_supply_ovl = 1'b0;
        dout_ovl       = 1'b0;
        failures       = 0;
        samples_checked = 0;
        void'($urandom(32'hD9F1B4B8));
        repeat (8) @(posedge mclk);
        #1;
        rstn = 1'b1;
        for (int i = 0; i < 9; i++)
            rd(C_IDX[i], C_EXP[i], 8'hFF);
        rd(5'($urandom_range(9, 15)), 8'h00, 8'hFF);
        rd(5'h1F, 8'h00, 8'hFF);
        // Every lost-alarm cause, with a dropped event while active
        for (int k = 0; k < 5; k++)
        begin
            pulse(5'h01, 1'b0);
            check_bit(proc_pending, 1'b1);
            repeat ($urandom_range(0, 3)) @(posedge mclk);
            pulse(5'(1 << k), 1'b0);
            wait_evt(1'b0);
            rd(cdr_pkg::IDX_FAULT_SUM, 8'h09, 8'hFF);
            rd(cdr_pkg::IDX_INT_DETAIL, 8'h40, 8'hFF);
            rd(cdr_pkg::IDX_GROUP_FAULTS, 8'h01, 8'hFF);
            rd(cdr_pkg::IDX_LOST_CAUSE, 8'(1 << k), 8'hFF);
            for (int b = 0; b < 4; b++)
            begin
                rd(5'(cdr_pkg::IDX_STAMP0 + 5'(b)), 8'h00, 8'h00);
                stamp[8*b +: 8] = last_rd;
            end
            check_stamp(stamp, 32'(evt_cyc / 100));
            pulse(5'h02, 1'b0);
            rd(cdr_pkg::IDX_LOST_CAUSE, 8'(1 << k), 8'hFF);
            // Event in the acknowledge cycle must not hold off the going alarm
            fork
                pulse(5'h04, 1'b0);
                rdr_u.ack_diag();
            join
            wait_evt(1'b1);
            rd(cdr_pkg::IDX_LOST_CAUSE, 8'h00, 8'hFF);
            pulse(5'h00, 1'b1);
            check_bit(proc_pending, 1'b0);
        end
        // Pending count climbs by two per overload cycle without acknowledge
        ovl(1'b0, 8'h10, 8'h00);
        for (int i = 0; i < 7; i++)
            ovl(1'b1, 8'h15, (i >= 5) ? 8'h08 : 8'h00);
        tally_and_finish();
    end
endmodule : counter_diagnostic_record_tb_top
